// File: common/fecr_pkg.sv
package fecr_pkg;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int V86_BIT        = 0;
    localparam int PVI_BIT        = 1;
    localparam int TS_RESTRICT_BIT = 2;
    localparam int DEBUG_BIT      = 3;
    localparam int LARGE_PAGE_BIT = 4;
    localparam int PHYS_EXT_BIT   = 5;
    localparam int MCHECK_BIT     = 6;
    localparam int GLOBAL_PAGE_BIT = 7;
    localparam int PERF_USER_BIT  = 8;
    localparam int STATE_SAVE_BIT = 9;
    localparam int SIMD_EXC_BIT   = 10;
    localparam int SEG_BASE_BIT   = 16;
    localparam int XSTATE_BIT     = 18;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [63:0] DEFINED_MASK = 64'h0000_0000_0005_07FF;
    localparam logic [63:0] FEC_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] PTR_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  CPL_KERNEL   = 2'h0;

    // ------------------------------------------------------------
    // Register selectors of the move instructions
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_FAULT_ADDR = 2'h0;
    localparam logic [1:0] SEL_TABLE_BASE = 2'h1;
    localparam logic [1:0] SEL_FEATURE    = 2'h2;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [1:0]  sel;
        logic        long_mode;
        logic [63:0] wdata;
    } fecr_move_t;

    typedef struct packed {
        logic        v86_enhancement_enable;
        logic        protected_virtual_irq_enable;
        logic        timestamp_read_restrict;
        logic        debug_extension_enable;
        logic        large_page_size_enable;
        logic        physical_address_extension_enable;
        logic        machine_check_enable;
        logic        global_page_enable;
        logic        perf_counter_user_enable;
        logic        os_state_save_support;
        logic        os_simd_exception_support;
        logic        segment_base_instr_enable;
        logic        extended_state_save_enable;
    } fecr_ctrl_t;

endpackage : fecr_pkg

// File: rtl/fecr_top.sv
module fecr_top (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Control-register move port
    input  wire fecr_pkg::fecr_move_t mv,
    output logic [63:0]            mv_rdata,
    output logic                   mv_ack,
    output logic                   gp_fault,
    output logic [15:0]            gp_error_code,
    // Page-fault address capture from the translation logic
    input  wire logic              pf_capture,
    input  wire logic [63:0]       pf_address,
    // Instruction context
    input  wire logic [1:0]        cpl,
    input  wire logic              v86_mode,
    input  wire logic              prot_mode,
    input  wire logic              ts_read_req,
    input  wire logic              intflag_instr,
    input  wire logic              soft_int_instr,
    input  wire logic              redirect_bit,
    // Decisions
    output logic                   ts_read_grant,
    output logic                   ts_read_fault,
    output logic                   use_virtual_if,
    output logic                   soft_int_redirect,
    // Control outputs
    output fecr_pkg::fecr_ctrl_t   ctrl,
    output logic [63:0]            translation_table_base,
    output logic [63:0]            page_fault_address,
    output logic [63:0]            feature_support
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [63:0] fec;
        logic [63:0] table_base;
        logic [63:0] fault_addr;
        logic [63:0] rdata;
        logic        ack;
        logic        gp;
        logic        ts_grant;
        logic        ts_fault;
        logic        virt_if;
        logic        redirect;
    } fecr_state_t;

    fecr_state_t st;
    fecr_state_t next_st;
    logic        wr_fault;
    logic [63:0] wr_value;

    fecr_write_check u_check (
        .wdata       (mv.wdata),
        .long_mode   (mv.long_mode),
        .fault       (wr_fault),
        .legal_value (wr_value)
    );

    function automatic logic [63:0] view(input logic [63:0] v, input logic lm);
        view = lm ? v : {32'h0000_0000, v[31:0]};
    endfunction : view

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.gp  = 1'b0;
        if (mv.req) begin
            next_st.ack = 1'b1;
            case (mv.sel)
                fecr_pkg::SEL_FAULT_ADDR: begin
                    next_st.rdata = view(st.fault_addr, mv.long_mode);
                    if (mv.wr) begin
                        next_st.fault_addr = mv.wdata;
                    end
                end
                fecr_pkg::SEL_TABLE_BASE: begin
                    next_st.rdata = view(st.table_base, mv.long_mode);
                    if (mv.wr) begin
                        next_st.table_base = mv.wdata;
                    end
                end
                fecr_pkg::SEL_FEATURE: begin
                    next_st.rdata = view(st.fec, mv.long_mode);
                    if (mv.wr) begin
                        if (wr_fault) begin
                            next_st.gp = 1'b1;
                        end else begin
                            next_st.fec = wr_value;
                        end
                    end
                end
                default: begin
                    next_st.rdata = 64'h0000_0000_0000_0000;
                end
            endcase
        end
        if (pf_capture) begin
            next_st.fault_addr = pf_address;
        end
        // Time-stamp privilege
        next_st.ts_grant = ts_read_req &&
            (!st.fec[fecr_pkg::TS_RESTRICT_BIT] || cpl == fecr_pkg::CPL_KERNEL);
        next_st.ts_fault = ts_read_req &&
            st.fec[fecr_pkg::TS_RESTRICT_BIT] && cpl != fecr_pkg::CPL_KERNEL;
        if (next_st.ts_fault) begin
            next_st.gp = 1'b1;
        end
        // Virtual interrupt handling
        next_st.virt_if = intflag_instr &&
            ((v86_mode && st.fec[fecr_pkg::V86_BIT])
            || (prot_mode && !v86_mode && st.fec[fecr_pkg::PVI_BIT]));
        next_st.redirect = soft_int_instr && v86_mode && st.fec[fecr_pkg::V86_BIT]
            && !redirect_bit;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{fec: fecr_pkg::FEC_RESET, table_base: fecr_pkg::PTR_RESET,
                    fault_addr: fecr_pkg::PTR_RESET, rdata: 64'h0000_0000_0000_0000,
                    default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mv_rdata               = st.rdata;
    assign mv_ack                 = st.ack;
    assign gp_fault               = st.gp;
    assign gp_error_code          = 16'h0000;
    assign ts_read_grant          = st.ts_grant;
    assign ts_read_fault          = st.ts_fault;
    assign use_virtual_if         = st.virt_if;
    assign soft_int_redirect      = st.redirect;
    assign translation_table_base = st.table_base;
    assign page_fault_address     = st.fault_addr;
    // All defined bits supported except perf counter, which is unreported
    assign feature_support = fecr_pkg::DEFINED_MASK
                           & ~(64'h1 << fecr_pkg::PERF_USER_BIT);
    assign ctrl = '{
        v86_enhancement_enable:            st.fec[fecr_pkg::V86_BIT],
        protected_virtual_irq_enable:      st.fec[fecr_pkg::PVI_BIT],
        timestamp_read_restrict:           st.fec[fecr_pkg::TS_RESTRICT_BIT],
        debug_extension_enable:            st.fec[fecr_pkg::DEBUG_BIT],
        large_page_size_enable:            st.fec[fecr_pkg::LARGE_PAGE_BIT],
        physical_address_extension_enable: st.fec[fecr_pkg::PHYS_EXT_BIT],
        machine_check_enable:              st.fec[fecr_pkg::MCHECK_BIT],
        global_page_enable:                st.fec[fecr_pkg::GLOBAL_PAGE_BIT],
        perf_counter_user_enable:          st.fec[fecr_pkg::PERF_USER_BIT],
        os_state_save_support:             st.fec[fecr_pkg::STATE_SAVE_BIT],
        os_simd_exception_support:         st.fec[fecr_pkg::SIMD_EXC_BIT],
        segment_base_instr_enable:         st.fec[fecr_pkg::SEG_BASE_BIT],
        extended_state_save_enable:        st.fec[fecr_pkg::XSTATE_BIT]
    };

endmodule : fecr_top

// File: rtl/fecr_write_check.sv
// ----------------------------------------------------------------
// Write legality check for the feature register
// ----------------------------------------------------------------
module fecr_write_check (
    // Write data and mode
    input  wire logic [63:0] wdata,
    input  wire logic        long_mode,
    // Verdict
    output logic             fault,
    output logic [63:0]      legal_value
);
    always_comb begin
        // Upper half must be zero in long mode; reserved low bits too
        fault = ((|wdata[63:32]) && long_mode)
              || (|(wdata[31:0] & ~fecr_pkg::DEFINED_MASK[31:0]));
        // Only defined bits are kept, in either mode
        legal_value = wdata & fecr_pkg::DEFINED_MASK;
    end
endmodule : fecr_write_check

// File: test/fecr_asserts.sv
module fecr_asserts (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Move port
    input wire fecr_pkg::fecr_move_t mv,
    input wire logic [63:0]          mv_rdata,
    input wire logic                 mv_ack,
    input wire logic                 gp_fault,
    input wire logic [15:0]          gp_error_code,
    // Context and decisions
    input wire logic                 pf_capture,
    input wire logic [63:0]          pf_address,
    input wire logic [1:0]           cpl,
    input wire logic                 v86_mode,
    input wire logic                 prot_mode,
    input wire logic                 ts_read_req,
    input wire logic                 intflag_instr,
    input wire logic                 soft_int_instr,
    input wire logic                 ts_read_grant,
    input wire logic                 ts_read_fault,
    input wire logic                 use_virtual_if,
    input wire logic                 soft_int_redirect,
    input wire fecr_pkg::fecr_ctrl_t ctrl,
    input wire logic [63:0]          page_fault_address,
    input wire logic [63:0]          feature_support
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fw;
    assign fw = mv.req && mv.wr && mv.sel == fecr_pkg::SEL_FEATURE;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_ACK: assert property (mv.req |=> mv_ack) else $error("ack missing");
    AST_LEGACY: assert property (mv.req && !mv.long_mode |=> mv_rdata[63:32] == 32'h0)
        else $error("legacy upper half set");
    AST_UPPER: assert property (fw && mv.long_mode && |mv.wdata[63:32] |=> gp_fault && $stable(ctrl))
        else $error("upper write not refused");
    AST_RSVD: assert property (fw && (mv.wdata[17] || |mv.wdata[15:11]) |=> gp_fault && $stable(ctrl))
        else $error("reserved write not refused");
    AST_GPCODE: assert property (gp_fault |-> gp_error_code == 16'h0) else $error("bad code");
    AST_TSOK: assert property (ts_read_req && (!ctrl.timestamp_read_restrict || cpl == 2'h0)
        |=> ts_read_grant && !ts_read_fault) else $error("read not granted");
    AST_TSBLK: assert property (ts_read_req && ctrl.timestamp_read_restrict && cpl != 2'h0
        |=> ts_read_fault && gp_fault && !ts_read_grant) else $error("read not blocked");
    AST_VME: assert property (intflag_instr && v86_mode && ctrl.v86_enhancement_enable
        |=> use_virtual_if) else $error("v86 flag not virtual");
    AST_PVI: assert property (intflag_instr && prot_mode && !v86_mode
        && ctrl.protected_virtual_irq_enable |=> use_virtual_if) else $error("pm flag not virtual");
    AST_NOREDIR: assert property (soft_int_instr && !v86_mode |=> !soft_int_redirect)
        else $error("redirect outside v86");
    AST_PF: assert property (pf_capture |=> page_fault_address == $past(pf_address))
        else $error("fault address not held");
    AST_SUP: assert property (feature_support == (fecr_pkg::DEFINED_MASK & ~64'h100))
        else $error("bad support mask");
endmodule : fecr_asserts

bind fecr_top fecr_asserts u_fecr_asserts (.*);

// File: test/fecr_top_tb.sv
module fecr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, rst, mv_ack, gp_fault, pf_capture, v86_mode, prot_mode, ts_read_req;
    logic intflag_instr, soft_int_instr, redirect_bit, ts_read_grant, ts_read_fault;
    logic use_virtual_if, soft_int_redirect;
    logic [1:0]  cpl;
    logic [15:0] gp_error_code;
    logic [63:0] mv_rdata, pf_address, translation_table_base, page_fault_address;
    logic [63:0] feature_support;
    fecr_pkg::fecr_move_t mv;
    fecr_pkg::fecr_ctrl_t ctrl;
    int errors = 0;
    int checks_done = 0;
    fecr_top u_fecr_top (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [63:0] g, input logic [63:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task op(input logic w, input logic [1:0] s, input logic l, input logic [63:0] d, input logic g);
        @(posedge clk) #1 mv = '{1'b1, w, s, l, d};
        @(posedge clk) #1 mv.req = 1'b0;
        chk({62'h0, mv_ack, gp_fault}, {62'h0, 1'b1, g});
    endtask : op
    task rd(input logic [1:0] s, input logic l, input logic [63:0] e);
        op(1'b0, s, l, 64'h0, 1'b0);
        chk(mv_rdata, e);
    endtask : rd
    task ev(input logic t, input logic i, input logic s, input logic [3:0] e);
        @(posedge clk) #1 {ts_read_req, intflag_instr, soft_int_instr} = {t, i, s};
        @(posedge clk) #1 {ts_read_req, intflag_instr, soft_int_instr} = 3'h0;
        chk({ts_read_grant, ts_read_fault, use_virtual_if, soft_int_redirect}, e);
    endtask : ev
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [63:0] m;
        mv = '0;
        {pf_capture, v86_mode, prot_mode, ts_read_req, intflag_instr} = 5'h0;
        {soft_int_instr, redirect_bit, cpl} = 4'h0;
        pf_address = 64'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        rd(2'h2, 1'b1, 64'h0);
        m = 64'h0;
        for (int i = 0; i < 20; i++) begin
            op(1'b1, 2'h2, 1'b0, 64'h1 << i, !fecr_pkg::DEFINED_MASK[i]);
            if (fecr_pkg::DEFINED_MASK[i]) m = 64'h1 << i;
            rd(2'h2, 1'b1, m);
        end
        op(1'b1, 2'h2, 1'b1, 64'h1_0000_0004, 1'b1);
        rd(2'h2, 1'b1, m);
        op(1'b1, 2'h2, 1'b0, 64'hFFFF_FFFF_0000_0004, 1'b0);
        rd(2'h2, 1'b0, 64'h4);
        $display("test register done");
        for (int c = 0; c < 4; c++) begin
            cpl = c[1:0];
            ev(1'b1, 1'b0, 1'b0, {c == 0, c != 0, 2'b00});
        end
        op(1'b1, 2'h2, 1'b0, 64'h0, 1'b0);
        ev(1'b1, 1'b0, 1'b0, 4'h8);
        op(1'b1, 2'h2, 1'b0, 64'h3, 1'b0);
        chk({51'h0, ctrl}, 64'h0000_0000_0000_1800);
        v86_mode = 1'b1;
        ev(1'b0, 1'b1, 1'b1, 4'h3);
        redirect_bit = 1'b1;
        ev(1'b0, 1'b0, 1'b1, 4'h0);
        {v86_mode, prot_mode} = 2'h1;
        ev(1'b0, 1'b1, 1'b1, 4'h2);
        op(1'b1, 2'h2, 1'b0, 64'h0, 1'b0);
        ev(1'b0, 1'b1, 1'b0, 4'h0);
        v86_mode = 1'b1;
        ev(1'b0, 1'b1, 1'b1, 4'h0);
        $display("test decisions done");
        op(1'b1, 2'h1, 1'b1, 64'hDEAD_BEEF_0123_4567, 1'b0);
        rd(2'h1, 1'b1, 64'hDEAD_BEEF_0123_4567);
        rd(2'h3, 1'b1, 64'h0);
        @(posedge clk) #1 {pf_capture, pf_address} = {1'b1, 64'hA5A5_0000_5A5A_1234};
        @(posedge clk) #1 pf_capture = 1'b0;
        chk(page_fault_address, 64'hA5A5_0000_5A5A_1234);
        chk(feature_support, 64'h0000_0000_0005_06FF);
        $display("test pointers done");
        give_verdict;
    end
    initial begin
        #20000;
        errors++;
        give_verdict;
    end
endmodule : fecr_top_tb
